// ===== logic/edr_pkg.sv
// Package with register map, field layout and reset values of the event destination router.
package edr_pkg;
   localparam int          EDR_NUM_DEST       = 64;
   localparam int          EDR_NUM_CHAN       = 7;
   localparam logic [11:0] EDR_OFS_SUBADDRESS = 12'hf9a;
   localparam logic [11:0] EDR_OFS_SUBDATA    = 12'hf9b;
   localparam logic [7:0]  EDR_RST_SUBADDRESS = 8'h00;
   localparam logic [7:0]  EDR_RST_SUBDATA    = 8'h00;
   localparam logic [3:0]  EDR_RST_ENTRY      = 4'h0;
   localparam int          EDR_SUBADDR_W      = 6;
   localparam int          EDR_ENTRY_W        = 4;
   localparam int          EDR_CONNECT_BIT    = 3;
   localparam int          EDR_CHSEL_MSB      = 2;
   localparam logic [5:0]  EDR_DST_CONVERT    = 6'h04;
   localparam logic [5:0]  EDR_DST_TIMER0_IN0 = 6'h10;
   localparam logic [5:0]  EDR_DST_TIMER0_IN1 = 6'h11;
   localparam logic [5:0]  EDR_DST_GPOUT0     = 6'h30;
   localparam int          EDR_NUM_GPOUT      = 4;
endpackage : edr_pkg

// ===== logic/edr_route_mux.sv
// Per-destination channel multiplexer with connect gating.
`timescale 1ns/100ps
module edr_route_mux (
   input  wire logic [edr_pkg::EDR_ENTRY_W-1:0]  entry_i,
   input  wire logic [edr_pkg::EDR_NUM_CHAN-1:0] chan_i,
   output logic                                  dest_o
);
   logic [edr_pkg::EDR_CHSEL_MSB:0] sel;
   assign sel = entry_i[edr_pkg::EDR_CHSEL_MSB:0];
   // Select code 111 has no channel and reads as logic 0.
   always_comb begin
      dest_o = 1'b0;
      if (entry_i[edr_pkg::EDR_CONNECT_BIT] && (int'(sel) < edr_pkg::EDR_NUM_CHAN)) begin
         dest_o = chan_i[sel];
      end
   end
endmodule : edr_route_mux

// ===== logic/edr_top.sv
// Event destination router: indirect subregister access over Avalon-MM and routing.
`timescale 1ns/100ps
// Function
// - Subaddress selects subregister reached via subdata
// - Subdata bits 3:0 read/write selected entry
// - Connect bit clear drives destination low
// - Bits 2:0 pick channel 0 to 6
// - Subaddress holds 6-bit selector, bits 7:6 read-only
// - Selector codes map to named peripheral inputs
module edr_top (
   input  wire logic                                  clk_sys_i,
   input  wire logic                                  resetn_i,
   input  wire logic [11:0]                           avs_address_i,
   input  wire logic                                  avs_read_i,
   input  wire logic                                  avs_write_i,
   input  wire logic [7:0]                            avs_writedata_i,
   output logic      [7:0]                            avs_readdata_o,
   output logic                                       avs_waitrequest_o,
   input  wire logic [edr_pkg::EDR_NUM_CHAN-1:0]      event_chan_i,
   output logic      [edr_pkg::EDR_NUM_DEST-1:0]      event_dest_o,
   output logic                                       convert_start_o,
   output logic      [1:0]                            timer0_in_o,
   output logic      [edr_pkg::EDR_NUM_GPOUT-1:0]     gp_event_o
);
   // Channels come from another domain of the chip, so they are synchronised first.
   logic [edr_pkg::EDR_NUM_CHAN-1:0] chan_meta_q;
   logic [edr_pkg::EDR_NUM_CHAN-1:0] chan_sync_q;
   logic [edr_pkg::EDR_SUBADDR_W-1:0] subaddr_q;
   logic [edr_pkg::EDR_SUBADDR_W-1:0] subaddr_d;
   logic [edr_pkg::EDR_ENTRY_W-1:0]   entry_q [edr_pkg::EDR_NUM_DEST];
   logic [edr_pkg::EDR_ENTRY_W-1:0]   entry_d [edr_pkg::EDR_NUM_DEST];
   logic [7:0]                        rdata_q;
   logic [7:0]                        rdata_d;
   logic                              ack_q;
   logic                              ack_d;
   logic [edr_pkg::EDR_NUM_DEST-1:0]  dest_q;
   logic [edr_pkg::EDR_NUM_DEST-1:0]  dest_d;

   function automatic logic hit(input logic [11:0] a, input logic [11:0] ofs);
      hit = (a == ofs);
   endfunction : hit

   // One wait state: every access completes at the second edge after it is raised.
   assign avs_waitrequest_o = (avs_read_i | avs_write_i) & ~ack_q;

   always_comb begin
      subaddr_d = subaddr_q;
      entry_d   = entry_q;
      rdata_d   = rdata_q;
      ack_d     = 1'b0;
      if ((avs_read_i | avs_write_i) && !ack_q) begin
         ack_d = 1'b1;
         // Read data is fetched in the wait state so that it stands at the accepting edge.
         if (avs_read_i) begin
            rdata_d = 8'h00;
            if (hit(avs_address_i, edr_pkg::EDR_OFS_SUBADDRESS)) begin
               rdata_d = {2'b00, subaddr_q};
            end else if (hit(avs_address_i, edr_pkg::EDR_OFS_SUBDATA)) begin
               rdata_d = {4'h0, entry_q[subaddr_q]};
            end
         end
      end
      // A write lands only at the edge where waitrequest is low, never in the wait state.
      if (avs_write_i && ack_q) begin
         if (hit(avs_address_i, edr_pkg::EDR_OFS_SUBADDRESS)) begin
            subaddr_d = avs_writedata_i[edr_pkg::EDR_SUBADDR_W-1:0];
         end else if (hit(avs_address_i, edr_pkg::EDR_OFS_SUBDATA)) begin
            // Upper bits are dropped, so a careless write of ones cannot set them.
            entry_d[subaddr_q] = avs_writedata_i[edr_pkg::EDR_ENTRY_W-1:0];
         end
      end
   end

   genvar g;
   generate
      for (g = 0; g < edr_pkg::EDR_NUM_DEST; g++) begin : g_dest
         edr_route_mux u_mux (
            .entry_i (entry_q[g]),
            .chan_i  (chan_sync_q),
            .dest_o  (dest_d[g])
         );
      end
   endgenerate

   always_ff @(posedge clk_sys_i or negedge resetn_i) begin
      if (!resetn_i) begin
         subaddr_q   <= edr_pkg::EDR_RST_SUBADDRESS[edr_pkg::EDR_SUBADDR_W-1:0];
         rdata_q     <= edr_pkg::EDR_RST_SUBDATA;
         ack_q       <= 1'b0;
         chan_meta_q <= '0;
         chan_sync_q <= '0;
         dest_q      <= '0;
         for (int i = 0; i < edr_pkg::EDR_NUM_DEST; i++) begin
            entry_q[i] <= edr_pkg::EDR_RST_ENTRY;
         end
      end else begin
         subaddr_q   <= subaddr_d;
         rdata_q     <= rdata_d;
         ack_q       <= ack_d;
         chan_meta_q <= event_chan_i;
         chan_sync_q <= chan_meta_q;
         dest_q      <= dest_d;
         entry_q     <= entry_d;
      end
   end

   assign avs_readdata_o  = rdata_q;
   assign event_dest_o    = dest_q;
   assign convert_start_o = dest_q[edr_pkg::EDR_DST_CONVERT];
   assign timer0_in_o     = {dest_q[edr_pkg::EDR_DST_TIMER0_IN1],
                             dest_q[edr_pkg::EDR_DST_TIMER0_IN0]};
   assign gp_event_o      = dest_q[edr_pkg::EDR_DST_GPOUT0 +: edr_pkg::EDR_NUM_GPOUT];

   // Assertions.
   property p_sub_write;
      @(posedge clk_sys_i) disable iff (!resetn_i)
      (avs_write_i && !avs_waitrequest_o && avs_address_i == edr_pkg::EDR_OFS_SUBADDRESS)
      |=> subaddr_q == $past(avs_writedata_i[5:0]);
   endproperty
   a_sub_write: assert property (p_sub_write) else $error("subaddress write lost");

   property p_entry_write;
      @(posedge clk_sys_i) disable iff (!resetn_i)
      (avs_write_i && !avs_waitrequest_o && avs_address_i == edr_pkg::EDR_OFS_SUBDATA)
      |=> entry_q[$past(subaddr_q)] == $past(avs_writedata_i[3:0]);
   endproperty
   a_entry_write: assert property (p_entry_write) else $error("entry write lost");

   property p_read_data;
      @(posedge clk_sys_i) disable iff (!resetn_i)
      (avs_read_i && avs_waitrequest_o && avs_address_i == edr_pkg::EDR_OFS_SUBDATA)
      |=> avs_readdata_o == {4'h0, entry_q[$past(subaddr_q)]};
   endproperty
   a_read_data: assert property (p_read_data) else $error("subdata read wrong");

   property p_read_upper;
      @(posedge clk_sys_i) disable iff (!resetn_i)
      (avs_read_i && !avs_waitrequest_o) |-> avs_readdata_o[7:6] == 2'b00;
   endproperty
   a_read_upper: assert property (p_read_upper) else $error("reserved bits set");

   property p_disconnect;
      @(posedge clk_sys_i) disable iff (!resetn_i)
      !entry_q[4][3] |=> !convert_start_o;
   endproperty
   a_disconnect: assert property (p_disconnect) else $error("disconnected dest high");

   property p_route;
      @(posedge clk_sys_i) disable iff (!resetn_i)
      (entry_q[4] == 4'hb) |=> convert_start_o == $past(chan_sync_q[3]);
   endproperty
   a_route: assert property (p_route) else $error("channel routing wrong");

   property p_wait_len;
      @(posedge clk_sys_i) disable iff (!resetn_i)
      $rose(avs_read_i | avs_write_i) |-> avs_waitrequest_o ##1 !avs_waitrequest_o;
   endproperty
   a_wait_len: assert property (p_wait_len) else $error("wait length wrong");

   property p_gp_route;
      @(posedge clk_sys_i) disable iff (!resetn_i)
      (entry_q[48][3] && entry_q[48][2:0] != 3'h7)
      |=> gp_event_o[0] == $past(chan_sync_q[entry_q[48][2:0]]);
   endproperty
   a_gp_route: assert property (p_gp_route) else $error("gp routing wrong");

   property p_reset_clear;
      @(posedge clk_sys_i) $rose(resetn_i) |-> event_dest_o == '0 && entry_q[0] == 4'h0;
   endproperty
   a_reset_clear: assert property (p_reset_clear) else $error("reset state wrong");

   property p_sub_read;
      @(posedge clk_sys_i) disable iff (!resetn_i)
      (avs_read_i && avs_waitrequest_o && avs_address_i == edr_pkg::EDR_OFS_SUBADDRESS)
      |=> avs_readdata_o == {2'b00, $past(subaddr_q)};
   endproperty
   a_sub_read: assert property (p_sub_read) else $error("subaddress read wrong");

   // A write must not land while waitrequest still holds the master off.
   property p_write_hold;
      @(posedge clk_sys_i) disable iff (!resetn_i)
      (avs_write_i && avs_waitrequest_o) |=> subaddr_q == $past(subaddr_q);
   endproperty
   a_write_hold: assert property (p_write_hold) else $error("write landed early");

   property p_data_keeps_sel;
      @(posedge clk_sys_i) disable iff (!resetn_i)
      (avs_write_i && !avs_waitrequest_o && avs_address_i == edr_pkg::EDR_OFS_SUBDATA)
      |=> subaddr_q == $past(subaddr_q);
   endproperty
   a_data_keeps_sel: assert property (p_data_keeps_sel) else $error("selector moved");

   property p_unmapped_read;
      @(posedge clk_sys_i) disable iff (!resetn_i)
      (avs_read_i && avs_waitrequest_o && avs_address_i != edr_pkg::EDR_OFS_SUBADDRESS
       && avs_address_i != edr_pkg::EDR_OFS_SUBDATA) |=> avs_readdata_o == 8'h00;
   endproperty
   a_unmapped_read: assert property (p_unmapped_read) else $error("unmapped read set");

   property p_timer_disc;
      @(posedge clk_sys_i) disable iff (!resetn_i)
      !entry_q[17][3] |=> !timer0_in_o[1];
   endproperty
   a_timer_disc: assert property (p_timer_disc) else $error("disconnected timer high");

   property p_reset_regs;
      @(posedge clk_sys_i)
      $rose(resetn_i) |-> {2'b00, subaddr_q} == edr_pkg::EDR_RST_SUBADDRESS
                          && avs_readdata_o == edr_pkg::EDR_RST_SUBDATA;
   endproperty
   a_reset_regs: assert property (p_reset_regs) else $error("register reset wrong");

   c_write: cover property (@(posedge clk_sys_i) avs_write_i && !avs_waitrequest_o);
   c_read: cover property (@(posedge clk_sys_i) avs_read_i && !avs_waitrequest_o);
   c_conn: cover property (@(posedge clk_sys_i) convert_start_o);
   c_gp: cover property (@(posedge clk_sys_i) gp_event_o[0]);
   c_timer: cover property (@(posedge clk_sys_i) timer0_in_o[1]);
endmodule : edr_top

// ===== dv/test_edr_top.sv
// Self-checking testbench for the event destination router.
`timescale 1ns/100ps
module test_edr_top;
   logic        clk_sys_i       = 1'b0;
   logic        resetn_i        = 1'b0;
   logic [11:0] avs_address_i   = 12'h000;
   logic        avs_read_i      = 1'b0;
   logic        avs_write_i     = 1'b0;
   logic [7:0]  avs_writedata_i = 8'h00;
   logic [6:0]  event_chan_i    = 7'h00;
   logic [7:0]  avs_readdata_o;
   logic        avs_waitrequest_o;
   logic [63:0] event_dest_o;
   logic        convert_start_o;
   logic [1:0]  timer0_in_o;
   logic [3:0]  gp_event_o;
   logic [3:0]  ent_m [64];
   logic [7:0]  rd;
   logic [63:0] exp_d;
   int          fail_count = 0;
   int          n_compared = 0;
   int          cyc        = 0;
   always #50 clk_sys_i = ~clk_sys_i;
   edr_top dut (.clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .avs_address_i(avs_address_i),
      .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
      .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
      .event_chan_i(event_chan_i), .event_dest_o(event_dest_o),
      .convert_start_o(convert_start_o), .timer0_in_o(timer0_in_o), .gp_event_o(gp_event_o));
   task finish_test;
      $display("compared %0d mismatches %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : finish_test
   // A hung handshake must still reach the closing report.
   always @(posedge clk_sys_i) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         fail_count++;
         finish_test();
      end
   end
   task check(input string nm, input logic [63:0] seen, input logic [63:0] exp);
      n_compared++;
      if (seen !== exp) begin
         fail_count++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
      end
   endtask : check
   // Waitrequest and read data are taken at the rising edge, before the design moves on.
   task bus(input logic wr, input logic [11:0] a, input logic [7:0] d);
      avs_address_i <= a;
      avs_writedata_i <= d;
      avs_write_i <= wr;
      avs_read_i <= !wr;
      @(posedge clk_sys_i);
      while (avs_waitrequest_o !== 1'b0) @(posedge clk_sys_i);
      rd = avs_readdata_o;
      avs_write_i <= 1'b0;
      avs_read_i <= 1'b0;
      @(posedge clk_sys_i);
   endtask : bus
   task set_entry(input int d, input logic [3:0] v);
      bus(1'b1, edr_pkg::EDR_OFS_SUBADDRESS, 8'(d));
      bus(1'b1, edr_pkg::EDR_OFS_SUBDATA, {4'h0, v});
      ent_m[d] = v;
   endtask : set_entry
   task check_routes;
      repeat (4) @(posedge clk_sys_i);
      for (int i = 0; i < 64; i++)
         exp_d[i] = ent_m[i][3] && ent_m[i][2:0] != 3'h7 && event_chan_i[ent_m[i][2:0]];
      check("dest", event_dest_o, exp_d);
      check("named", {convert_start_o, timer0_in_o, gp_event_o},
            {exp_d[4], exp_d[17:16], exp_d[51:48]});
   endtask : check_routes
   task do_reset;
      resetn_i <= 1'b0;
      repeat (2) @(posedge clk_sys_i);
      resetn_i <= 1'b1;
      @(posedge clk_sys_i);
      for (int i = 0; i < 64; i++) ent_m[i] = 4'h0;
   endtask : do_reset
   initial begin
      do_reset();
      bus(1'b0, edr_pkg::EDR_OFS_SUBADDRESS, 8'h00);
      check("subaddress", rd, edr_pkg::EDR_RST_SUBADDRESS);
      bus(1'b0, edr_pkg::EDR_OFS_SUBDATA, 8'h00);
      check("subdata", rd, edr_pkg::EDR_RST_SUBDATA);
      event_chan_i <= 7'h7f;
      check_routes();
      $display("test reset values done");
      for (int i = 0; i < 64; i += 9) set_entry(i, 4'(i + 3));
      for (int i = 0; i < 64; i += 9) begin
         bus(1'b1, edr_pkg::EDR_OFS_SUBADDRESS, 8'(i));
         bus(1'b0, edr_pkg::EDR_OFS_SUBDATA, 8'h00);
         check("entry", rd, {4'h0, ent_m[i]});
      end
      // Reserved selector bits are written as ones on purpose to see them refused.
      bus(1'b1, edr_pkg::EDR_OFS_SUBADDRESS, 8'hff);
      bus(1'b0, edr_pkg::EDR_OFS_SUBADDRESS, 8'h00);
      check("subaddress", rd, 8'h3f);
      bus(1'b0, 12'h000, 8'h00);
      check("unmapped", rd, 8'h00);
      $display("test access done");
      for (int ch = 0; ch < 8; ch++) begin
         set_entry(4, 4'(8 + ch));
         set_entry(16 + ch % 2, 4'(8 + ch));
         set_entry(48 + ch % 4, 4'(8 + ch));
         event_chan_i <= 7'(1 << ch);
         check_routes();
         event_chan_i <= ~7'(1 << ch);
         check_routes();
         set_entry(4, 4'(ch));
         check_routes();
      end
      $display("test routing done");
      do_reset();
      check_routes();
      bus(1'b0, edr_pkg::EDR_OFS_SUBDATA, 8'h00);
      check("subdata", rd, 8'h00);
      $display("test second reset done");
      finish_test();
   end
endmodule : test_edr_top
